// ### src/lpmr_defines.vh
// Constants for the mode-register bank at addresses 03h..08h
`ifndef LPMR_DEFINES_VH
`define LPMR_DEFINES_VH

`define LPMR_MA_W            8
`define LPMR_OP_W            8
`define LPMR_MA_IO_DRIVE     8'h03
`define LPMR_MA_TEMP_STATUS  8'h04
`define LPMR_MA_MAKER_ID     8'h05
`define LPMR_MA_REV_FIRST    8'h06
`define LPMR_MA_REV_SECOND   8'h07
`define LPMR_MA_DESCRIPTOR   8'h08

`define LPMR_DS_W            4
`define LPMR_DS_RESET        4'h2
`define LPMR_DS_34R3         4'h1
`define LPMR_DS_40R          4'h2
`define LPMR_DS_48R          4'h3
`define LPMR_DS_60R          4'h4
`define LPMR_DS_80R          4'h6
`define LPMR_DS_120R         4'h7

`define LPMR_RATE_W          3
`define LPMR_RATE_RESET      3'h3
`define LPMR_RATE_LOW_LIMIT  3'h0
`define LPMR_RATE_X4         3'h1
`define LPMR_RATE_X2         3'h2
`define LPMR_RATE_X1         3'h3
`define LPMR_RATE_RSVD       3'h4
`define LPMR_RATE_Q_NODER    3'h5
`define LPMR_RATE_Q_DERATE   3'h6
`define LPMR_RATE_HIGH_LIMIT 3'h7
`define LPMR_RATE_HOT_BIT    2

`define LPMR_TYPE_NVM        2'h2
`define LPMR_TYPE_RSVD       2'h3
`define LPMR_DENS_MAX        4'h9
`define LPMR_WIDTH_UNUSED    2'h3

`define LPMR_MAKER_ID_DEF    8'h5a
`define LPMR_REV_FIRST_DEF   8'h10
`define LPMR_REV_SECOND_DEF  8'h20
`define LPMR_TYPE_DEF        2'h0
`define LPMR_DENS_DEF        4'h6
`define LPMR_WIDTH_DEF       2'h1

`endif

// ### src/lpmr_temp_flag.v
// Temperature refresh-rate capture with sticky update flag
`timescale 1ns/1ps
`default_nettype none
`include "lpmr_defines.vh"
module lpmr_temp_flag (
  input  wire                    clk_i,
  input  wire                    rst_n_i,
  input  wire [`LPMR_RATE_W-1:0] rate_i,
  input  wire                    status_read_i,
  output reg  [`LPMR_RATE_W-1:0] rate_o,
  output reg                     flag_o
);
  wire rate_changed;

  assign rate_changed = (rate_i != rate_o);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_o <= `LPMR_RATE_RESET;
      flag_o <= 1'b0;
    end else begin
      rate_o <= rate_i;
      if (rate_changed) begin
        flag_o <= 1'b1;
      end else if (status_read_i) begin
        flag_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### src/lpmr_bank.v
// Mode-register bank, addresses 03h..08h, read/write over command port
// How it works
// - Address 03h: write-only 4-bit drive-strength code, bits 7:4 reserved.
// - Codes 1,2,3,4,6,7 select 34.3..120 ohm; default 2; others reserved.
// - Address 04h reads rate code in bits 2:0, update flag bit 7.
// - Rate codes 1..3 are 4x,2x,1x; 5 and 6 quarter; 4 reserved.
// - Rate 0 and 7 report low or high temperature limit exceeded.
// - Rate bit 2 set means die temperature above 85 degrees.
// - Reading address 04h clears the update flag; a rate change in the same cycle sets it instead.
// - Update flag is zero after reset until a rate change.
// - Address 05h returns fixed 8-bit maker identity.
// - Address 06h returns first revision identity.
// - Address 07h returns second revision identity.
// - Address 08h returns type, density and I/O width descriptor.
// - Density 0..9 doubles from 64Mb; width 0 x32, 1 x16, 2 x8.
`timescale 1ns/1ps
`default_nettype none
`include "lpmr_defines.vh"
module lpmr_bank #(
  parameter [`LPMR_OP_W-1:0] MAKER_ID   = `LPMR_MAKER_ID_DEF,
  parameter [`LPMR_OP_W-1:0] REV_FIRST  = `LPMR_REV_FIRST_DEF,
  parameter [`LPMR_OP_W-1:0] REV_SECOND = `LPMR_REV_SECOND_DEF,
  parameter [1:0]            MEM_TYPE   = `LPMR_TYPE_DEF,
  parameter [3:0]            DENSITY    = `LPMR_DENS_DEF,
  parameter [1:0]            IO_WIDTH   = `LPMR_WIDTH_DEF
) (
  input  wire                    clk_i,
  input  wire                    rst_n_i,
  input  wire                    mrw_i,
  input  wire                    mrr_i,
  input  wire [`LPMR_MA_W-1:0]   ma_i,
  input  wire [`LPMR_OP_W-1:0]   op_i,
  input  wire [`LPMR_RATE_W-1:0] sensor_rate_i,
  output reg  [`LPMR_OP_W-1:0]   rd_data_o,
  output reg                     rd_valid_o,
  output reg                     rd_hit_o,
  output wire [`LPMR_DS_W-1:0]   drive_strength_code_o,
  output wire                    derate_o,
  output wire                    temp_limit_o,
  output wire                    temp_hot_o
);
  reg  [`LPMR_DS_W-1:0]   drive_strength_code_r;
  reg  [`LPMR_OP_W-1:0]   rd_nxt;
  reg                     hit_nxt;
  wire [`LPMR_RATE_W-1:0] rate;
  wire                    temp_update_flag;
  wire                    status_read;
  wire [`LPMR_OP_W-1:0]   descriptor;

  // Only the defined drive-strength codes are accepted
  function ds_legal;
    input [`LPMR_DS_W-1:0] code;
    begin
      case (code)
        `LPMR_DS_34R3,
        `LPMR_DS_40R,
        `LPMR_DS_48R,
        `LPMR_DS_60R,
        `LPMR_DS_80R,
        `LPMR_DS_120R: ds_legal = 1'b1;
        default:       ds_legal = 1'b0;
      endcase
    end
  endfunction

  // Identity descriptor fields; reserved encodings forced to legal
  function [`LPMR_OP_W-1:0] make_desc;
    input [1:0] t;
    input [3:0] d;
    input [1:0] w;
    reg   [1:0] tt;
    reg   [3:0] dd;
    reg   [1:0] ww;
    begin
      tt = (t == `LPMR_TYPE_RSVD) ? `LPMR_TYPE_DEF : t;
      dd = (d > `LPMR_DENS_MAX) ? `LPMR_DENS_DEF : d;
      ww = (w == `LPMR_WIDTH_UNUSED) ? `LPMR_WIDTH_DEF : w;
      make_desc = {ww, dd, tt};
    end
  endfunction

  assign descriptor = make_desc(MEM_TYPE, DENSITY, IO_WIDTH);
  assign status_read = mrr_i && (ma_i == `LPMR_MA_TEMP_STATUS);

  lpmr_temp_flag u_temp_flag (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .rate_i        (sensor_rate_i),
    .status_read_i (status_read),
    .rate_o        (rate),
    .flag_o        (temp_update_flag)
  );

  // Write path: only 03h is writable, reserved codes dropped
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_strength_code_r <= `LPMR_DS_RESET;
    end else if (mrw_i && (ma_i == `LPMR_MA_IO_DRIVE) &&
                 ds_legal(op_i[`LPMR_DS_W-1:0])) begin
      drive_strength_code_r <= op_i[`LPMR_DS_W-1:0];
    end
  end

  // Read mux; 03h is write-only and reads zero
  always @* begin
    rd_nxt  = {`LPMR_OP_W{1'b0}};
    hit_nxt = 1'b1;
    case (ma_i)
      `LPMR_MA_IO_DRIVE:    rd_nxt = {`LPMR_OP_W{1'b0}};
      `LPMR_MA_TEMP_STATUS: rd_nxt = {temp_update_flag, 4'h0,
                                      rate};
      `LPMR_MA_MAKER_ID:    rd_nxt = MAKER_ID;
      `LPMR_MA_REV_FIRST:   rd_nxt = REV_FIRST;
      `LPMR_MA_REV_SECOND:  rd_nxt = REV_SECOND;
      `LPMR_MA_DESCRIPTOR:  rd_nxt = descriptor;
      default:              hit_nxt = 1'b0;
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o  <= {`LPMR_OP_W{1'b0}};
      rd_valid_o <= 1'b0;
      rd_hit_o   <= 1'b0;
    end else begin
      rd_valid_o <= mrr_i;
      rd_hit_o   <= mrr_i && hit_nxt;
      if (mrr_i) begin
        rd_data_o <= rd_nxt;
      end
    end
  end

  assign drive_strength_code_o = drive_strength_code_r;
  assign derate_o     = (rate == `LPMR_RATE_Q_DERATE);
  assign temp_limit_o = (rate == `LPMR_RATE_LOW_LIMIT) ||
                        (rate == `LPMR_RATE_HIGH_LIMIT);
  assign temp_hot_o   = rate[`LPMR_RATE_HOT_BIT];
endmodule
`default_nettype wire

// ### testbench/lpmr_host.sv
// Controller model issuing mode-register commands
`timescale 1ns/1ps
`default_nettype none
module lpmr_host (
  input  wire logic       clk_i,
  output var  logic       mrw_o,
  output var  logic       mrr_o,
  output var  logic [7:0] ma_o,
  output var  logic [7:0] op_o
);
  initial {mrw_o, mrr_o, ma_o, op_o} = 18'h0;
  task automatic cmd(input logic w, input logic [7:0] a, d);
    {mrw_o, mrr_o, ma_o, op_o} = {w, !w, a, d};
    @(negedge clk_i);
  endtask
  // Released bus shows inverted values
  task automatic idle();
    {mrw_o, mrr_o, ma_o, op_o} = {2'b00, ~ma_o, ~op_o};
    @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### testbench/lpmr_bank_chk.sv
// Assertion checker for the mode-register bank
`timescale 1ns/1ps
`default_nettype none
module lpmr_chk #(parameter [7:0] MID = 8'h0) (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       mrw_i,
  input wire logic       mrr_i,
  input wire logic [7:0] ma_i,
  input wire logic [7:0] op_i,
  input wire logic [2:0] sensor_rate_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       rd_valid_o,
  input wire logic       rd_hit_o,
  input wire logic [3:0] drive_strength_code_o,
  input wire logic       temp_hot_o
);
  wire ds_ok = mrw_i && ma_i == 8'h03 && op_i[3:0] inside {[1:4], 6, 7};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd(a);
    mrr_i && ma_i == a ##1 rd_valid_o;
  endsequence
  a_ds_write: assert property (ds_ok |=>
    {4'h0, drive_strength_code_o} == ($past(op_i) & 8'h0f)) else $error("ds");
  a_ds_ignore: assert property (mrw_i && !ds_ok |=>
    $stable(drive_strength_code_o)) else $error("ds kept");
  a_wo_read: assert property (s_rd(8'h03) |->
    rd_hit_o && rd_data_o == 8'h00) else $error("wo read");
  a_rate_read: assert property (s_rd(8'h04) |->
    rd_data_o[6:0] == {4'h0, $past(sensor_rate_i, 2)}) else $error("rate");
  a_flag_set: assert property ($changed(sensor_rate_i) ##1
    s_rd(8'h04) |-> rd_data_o[7]) else $error("flag");
  a_flag_clear: assert property ((mrr_i && ma_i == 8'h04 &&
    $stable(sensor_rate_i)) [*2] |=> !rd_data_o[7]) else $error("clr");
  a_hot_rate: assert property (1'b1 |=>
    temp_hot_o == $past(sensor_rate_i[2])) else $error("hot");
  a_maker_id: assert property (s_rd(8'h05) |->
    rd_data_o == MID) else $error("id");
endmodule
bind lpmr_bank lpmr_chk #(.MID(MAKER_ID)) chk (
  .clk_i                 (clk_i),
  .rst_n_i               (rst_n_i),
  .mrw_i                 (mrw_i),
  .mrr_i                 (mrr_i),
  .ma_i                  (ma_i),
  .op_i                  (op_i),
  .sensor_rate_i         (sensor_rate_i),
  .rd_data_o             (rd_data_o),
  .rd_valid_o            (rd_valid_o),
  .rd_hit_o              (rd_hit_o),
  .drive_strength_code_o (drive_strength_code_o),
  .temp_hot_o            (temp_hot_o)
);
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the mode-register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk_i = 1'b0, rst_n_i = 1'b0, mrw_i, mrr_i;
  logic       rd_valid_o, rd_hit_o, derate_o, temp_limit_o, temp_hot_o;
  logic [7:0] ma_i, op_i, rd_data_o, ids [4] = '{8'h5a, 8'h10, 8'h20, 8'h58};
  logic [3:0] drive_strength_code_o, ds = 4'h2;
  logic [2:0] sensor_rate_i = 3'h3;
  int         mismatches = 0, tests_run = 0;
  initial forever #50 clk_i = ~clk_i;
  lpmr_host host (.clk_i(clk_i), .mrw_o(mrw_i), .mrr_o(mrr_i), .ma_o(ma_i),
    .op_o(op_i));
  lpmr_bank uut (
    .clk_i                 (clk_i),
    .rst_n_i               (rst_n_i),
    .mrw_i                 (mrw_i),
    .mrr_i                 (mrr_i),
    .ma_i                  (ma_i),
    .op_i                  (op_i),
    .sensor_rate_i         (sensor_rate_i),
    .rd_data_o             (rd_data_o),
    .rd_valid_o            (rd_valid_o),
    .rd_hit_o              (rd_hit_o),
    .drive_strength_code_o (drive_strength_code_o),
    .derate_o              (derate_o),
    .temp_limit_o          (temp_limit_o),
    .temp_hot_o            (temp_hot_o)
  );
  task automatic cmp(input string n, input logic [7:0] e, s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, e, input logic h);
    host.cmd(1'b0, a, 8'h00);
    cmp("flags", {6'h0, h, 1'b1}, {6'h0, rd_hit_o, rd_valid_o});
    cmp("data", e, rd_data_o);
    host.idle();
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    rd(8'h04, 8'h03, 1'b1);
    rd(8'h03, 8'h00, 1'b1);
    for (int c = 15; c >= 0; c--) begin
      if (c inside {[1:4], 6, 7}) ds = 4'(c);
      host.cmd(1'b1, 8'h03, 8'(c));
      cmp("ds", 8'(ds), 8'(drive_strength_code_o));
    end
    for (int i = 0; i < 4; i++) begin
      host.cmd(1'b1, 8'(i + 5), 8'hff);
      rd(8'(i + 5), ids[i], 1'b1);
    end
    rd(8'h09, 8'h00, 1'b0);
    for (int r = 0; r < 8; r++) begin
      sensor_rate_i = 3'(r);
      @(negedge clk_i);
      cmp("temp", 8'({r[2], r == 6, r == 0 || r == 7}),
        8'({temp_hot_o, derate_o, temp_limit_o}));
      cmp("derate", 8'(r == 6), 8'(derate_o));
      rd(8'h04, {1'b1, 4'h0, 3'(r)}, 1'b1);
    end
    sensor_rate_i = 3'h3;
    @(negedge clk_i);
    host.cmd(1'b0, 8'h04, 8'h00);
    cmp("data", 8'h83, rd_data_o);
    rd(8'h04, 8'h03, 1'b1);
    sensor_rate_i = 3'h5;
    rd(8'h04, 8'h03, 1'b1);
    rd(8'h04, 8'h85, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
